//--- status_word_defs.svh
// status word, banking and exception constants for the exception unit
// assumes a 32-bit core datapath and APB register access
`ifndef STATUS_WORD_DEFS_SVH
`define STATUS_WORD_DEFS_SVH

// ----------------------------------------
// mode encodings
// ----------------------------------------
`define MODE_USER 5'h10
`define MODE_FIQ 5'h11
`define MODE_IRQ 5'h12
`define MODE_SVC 5'h13
`define MODE_ABT 5'h17
`define MODE_UND 5'h1B
`define MODE_SYS 5'h1F

// ----------------------------------------
// status word field positions
// ----------------------------------------
`define PSR_FLAGS_HI 31
`define PSR_FLAGS_LO 28
`define PSR_IMASK_BIT 7
`define PSR_FMASK_BIT 6
`define PSR_STATE_BIT 5
`define PSR_MODE_HI 4
`define PSR_MODE_LO 0
`define PSR_RESET 32'h000000D3

// ----------------------------------------
// vectors and return offsets
// ----------------------------------------
`define VEC_LOW_BASE 32'h00000000
`define VEC_HIGH_BASE 32'hFFFF0000
`define VEC_RESET 32'h00000000
`define VEC_UND 32'h00000004
`define VEC_SWT 32'h00000008
`define VEC_PABT 32'h0000000C
`define VEC_DABT 32'h00000010
`define VEC_IRQ 32'h00000018
`define VEC_FIQ 32'h0000001C
`define LR_OFS_2 32'h00000002
`define LR_OFS_4 32'h00000004
`define LR_OFS_8 32'h00000008

// ----------------------------------------
// APB register offsets, control field
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_CUR 12'h004
`define REG_SAVED 12'h008
`define REG_INFO 12'h00C
`define CTRL_HIVEC_BIT 0
`define CTRL_RESET 32'h00000000

// ----------------------------------------
// physical register file layout
// ----------------------------------------
`define PHYS_REGS 30
`define PHYS_FIQ_BASE 5'h0F
`define PHYS_BANK_BASE 5'h16
`define SAVED_NONE 3'h7

`endif

//--- status_word_pkg.sv
// types shared by the exception unit
// assumes status_word_defs.svh for all numeric constants
package status_word_pkg;

   // ----------------------------------------
   // status word layout
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] nzcv;
      logic [19:0] rsvd;
      logic imask;
      logic fmask;
      logic state;
      logic [4:0] mode;
   } psr_t;

   typedef enum logic [2:0] {
      EXC_NONE,
      EXC_RESET,
      EXC_DABT,
      EXC_FIQ,
      EXC_IRQ,
      EXC_PABT,
      EXC_UND,
      EXC_SWT
   } exc_t;

   // ----------------------------------------
   // whole module state
   // ----------------------------------------
   typedef struct packed {
      psr_t cur;
      psr_t [4:0] saved;
      logic [29:0][31:0] gpr;
      logic hivec;
      logic rst_pend;
      logic locked;
      exc_t last_exc;
      logic ready;
      logic slverr;
      logic [31:0] prdata;
      logic [31:0] rd_data;
      logic acc_err;
      logic cond_pass;
      logic pc_load;
      logic [31:0] pc;
   } state_t;

endpackage

//--- status_word_and_exception_entry.sv
// status words, banked register file, exception entry and return
// assumes the core presents pc, requests and register accesses synchronously
//
// Overview of operation
// - compact low regs, SP, LR, PC are the full-state registers 0-7, 13, 14, 15
// - compact state reaches registers 8-12 only with the high-register variant strobe
// - one current word and five saved words, same in both states
// - four flags updated by operations and tested for conditional execution
// - full state conditions every instruction, compact state only branches
// - low eight bits change on entry; software writes them, except the state bit, only when privileged
// - set masks ignore normal and fast interrupt requests
// - state bit selects compact or full state and drives the state pin
// - seven legal mode encodings, all others invalid
// - fast mode banks 8-14, other exception modes bank 13-14, each saved word
// - simultaneous exceptions are taken in a fixed order
// - entry other than reset from full state saves pc plus 4 or 8 in the new link register
// - entry from compact state adjusts the link value for a common return
// - entry other than reset copies the current word into the new mode's saved word
// - entry forces the mode and loads the exception vector
// - entry sets masks to block unmanageable nesting
// - entry from compact state switches to full state with the vector
// - return loads pc from adjusted link, masks restored as saved
// - return copies the saved word back, restoring the state bit
// - vectors at low or high base, one word apart except two words from data abort to normal interrupt
// - order: reset, data abort, fast, normal, prefetch abort, undefined/trap
`timescale 1ns/1ns
`include "status_word_defs.svh"

module status_word_and_exception_entry #(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic boundary_i,
   input wire logic [31:0] pc_i,
   input wire logic dabt_i,
   input wire logic fiq_i,
   input wire logic irq_i,
   input wire logic pabt_i,
   input wire logic undef_i,
   input wire logic swtrap_i,
   input wire logic ret_i,
   input wire logic [31:0] ret_pc_i,
   input wire logic flag_we_i,
   input wire logic [3:0] flags_i,
   input wire logic [3:0] cond_i,
   input wire logic branch_i,
   input wire logic [3:0] rd_idx_i,
   input wire logic hi_ok_i,
   input wire logic wr_en_i,
   input wire logic [3:0] wr_idx_i,
   input wire logic [31:0] wr_data_i,
   output logic [31:0] rd_data_o,
   output logic acc_err_o,
   output logic cond_pass_o,
   output logic pc_load_o,
   output logic [31:0] pc_o,
   output logic state_indicator_output_o,
   output logic [4:0] mode_o,
   output logic locked_o
);

   // ----------------------------------------
   // helper functions
   // ----------------------------------------
   function automatic logic mode_legal(input logic [4:0] m);
      mode_legal = (m == `MODE_USER) || (m == `MODE_FIQ) || (m == `MODE_IRQ) ||
                   (m == `MODE_SVC) || (m == `MODE_ABT) || (m == `MODE_UND) ||
                   (m == `MODE_SYS);
   endfunction

   // saved word slot per mode; user and system have none
   function automatic logic [2:0] saved_idx(input logic [4:0] m);
      unique case (m)
         `MODE_FIQ: saved_idx = 3'h0;
         `MODE_IRQ: saved_idx = 3'h1;
         `MODE_SVC: saved_idx = 3'h2;
         `MODE_ABT: saved_idx = 3'h3;
         `MODE_UND: saved_idx = 3'h4;
         default: saved_idx = `SAVED_NONE;
      endcase
   endfunction

   // logical index to physical slot; 15 is the pc and never stored
   function automatic logic [4:0] phys(input logic [4:0] m, input logic [3:0] idx);
      logic [2:0] sv;
      sv = saved_idx(m);
      phys = {1'b0, idx};
      if (m == `MODE_FIQ && idx >= 4'h8 && idx <= 4'hE) begin
         phys = 5'(`PHYS_FIQ_BASE + 5'(idx - 4'h8));
      end else if (sv != `SAVED_NONE && sv != 3'h0 && idx >= 4'hD && idx <= 4'hE) begin
         phys = 5'(`PHYS_BANK_BASE + 5'({sv - 3'h1, 1'b0}) + 5'(idx - 4'hD));
      end
   endfunction

   // compact state: 0-7, 13, 14, 15 direct; 8-12 only via high variants
   function automatic logic acc_ok(input logic compact, input logic [3:0] idx,
                                   input logic hi);
      acc_ok = !compact || idx < 4'h8 || idx > 4'hC || hi;
   endfunction

   function automatic logic cond_eval(input logic [3:0] c, input logic [3:0] f);
      logic n;
      logic z;
      logic cy;
      logic v;
      {n, z, cy, v} = f;
      unique case (c)
         4'h0: cond_eval = z;
         4'h1: cond_eval = !z;
         4'h2: cond_eval = cy;
         4'h3: cond_eval = !cy;
         4'h4: cond_eval = n;
         4'h5: cond_eval = !n;
         4'h6: cond_eval = v;
         4'h7: cond_eval = !v;
         4'h8: cond_eval = cy && !z;
         4'h9: cond_eval = !cy || z;
         4'hA: cond_eval = n == v;
         4'hB: cond_eval = n != v;
         4'hC: cond_eval = !z && (n == v);
         4'hD: cond_eval = z || (n != v);
         default: cond_eval = 1'b1;
      endcase
   endfunction

   function automatic logic [4:0] exc_mode(input status_word_pkg::exc_t e);
      unique case (e)
         status_word_pkg::EXC_DABT, status_word_pkg::EXC_PABT: exc_mode = `MODE_ABT;
         status_word_pkg::EXC_FIQ: exc_mode = `MODE_FIQ;
         status_word_pkg::EXC_IRQ: exc_mode = `MODE_IRQ;
         status_word_pkg::EXC_UND: exc_mode = `MODE_UND;
         default: exc_mode = `MODE_SVC;
      endcase
   endfunction

   function automatic logic [31:0] exc_vec(input status_word_pkg::exc_t e);
      unique case (e)
         status_word_pkg::EXC_DABT: exc_vec = `VEC_DABT;
         status_word_pkg::EXC_PABT: exc_vec = `VEC_PABT;
         status_word_pkg::EXC_FIQ: exc_vec = `VEC_FIQ;
         status_word_pkg::EXC_IRQ: exc_vec = `VEC_IRQ;
         status_word_pkg::EXC_UND: exc_vec = `VEC_UND;
         status_word_pkg::EXC_SWT: exc_vec = `VEC_SWT;
         default: exc_vec = `VEC_RESET;
      endcase
   endfunction

   // compact offsets differ only for undefined and trap, so one handler return works
   function automatic logic [31:0] lr_ofs(input status_word_pkg::exc_t e, input logic compact);
      if (e == status_word_pkg::EXC_DABT) begin
         lr_ofs = `LR_OFS_8;
      end else if (compact &&
                   (e == status_word_pkg::EXC_UND || e == status_word_pkg::EXC_SWT)) begin
         lr_ofs = `LR_OFS_2;
      end else begin
         lr_ofs = `LR_OFS_4;
      end
   endfunction

   // ----------------------------------------
   // exception selection
   // ----------------------------------------
   status_word_pkg::state_t s_r;
   status_word_pkg::state_t s_nxt;
   status_word_pkg::exc_t sel;
   logic [31:0] vbase;

   assign vbase = s_r.hivec ? `VEC_HIGH_BASE : `VEC_LOW_BASE;

   always_comb begin
      sel = status_word_pkg::EXC_NONE;
      if (s_r.rst_pend) begin
         sel = status_word_pkg::EXC_RESET;
      end else if (!s_r.locked && boundary_i) begin
         if (dabt_i) begin
            sel = status_word_pkg::EXC_DABT;
         end else if (fiq_i && !s_r.cur.fmask) begin
            sel = status_word_pkg::EXC_FIQ;
         end else if (irq_i && !s_r.cur.imask) begin
            sel = status_word_pkg::EXC_IRQ;
         end else if (pabt_i) begin
            sel = status_word_pkg::EXC_PABT;
         end else if (undef_i) begin
            sel = status_word_pkg::EXC_UND;
         end else if (swtrap_i) begin
            sel = status_word_pkg::EXC_SWT;
         end
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [2:0] sv;
      logic [2:0] nsv;
      logic [4:0] nm;
      logic priv;
      logic compact;
      logic apb_wr;
      logic [ADDR_W-1:0] ofs;
      status_word_pkg::psr_t wpsr;
      sv = saved_idx(s_r.cur.mode);
      nm = exc_mode(sel);
      nsv = saved_idx(nm);
      priv = s_r.cur.mode != `MODE_USER;
      compact = s_r.cur.state;
      ofs = paddr_i;
      wpsr = status_word_pkg::psr_t'(pwdata_i);
      s_nxt = s_r;
      s_nxt.pc_load = 1'b0;
      s_nxt.ready = 1'b0;
      s_nxt.slverr = 1'b0;
      apb_wr = psel_i && penable_i && pwrite_i && s_r.ready && !s_r.slverr;
      // apb: decode in setup, answer in the first access cycle
      if (psel_i && !penable_i) begin
         s_nxt.ready = 1'b1;
         s_nxt.prdata = 32'h00000000;
         unique case (ofs)
            ADDR_W'(`REG_CTRL): s_nxt.prdata[`CTRL_HIVEC_BIT] = s_r.hivec;
            ADDR_W'(`REG_CUR): s_nxt.prdata = 32'(s_r.cur);
            ADDR_W'(`REG_SAVED): s_nxt.prdata = (sv == `SAVED_NONE) ? 32'h00000000 :
                                               32'(s_r.saved[sv]);
            ADDR_W'(`REG_INFO): s_nxt.prdata = {28'h0000000, s_r.locked, 3'(s_r.last_exc)};
            default: s_nxt.slverr = 1'b1;
         endcase
      end
      if (apb_wr && ofs == ADDR_W'(`REG_CTRL)) begin
         s_nxt.hivec = pwdata_i[`CTRL_HIVEC_BIT];
      end
      // flags always writable, control bits only when privileged; state bit kept
      if (apb_wr && ofs == ADDR_W'(`REG_CUR)) begin
         s_nxt.cur.nzcv = wpsr.nzcv;
         if (priv) begin
            s_nxt.cur.imask = wpsr.imask;
            s_nxt.cur.fmask = wpsr.fmask;
            s_nxt.cur.mode = wpsr.mode;
         end
      end
      if (apb_wr && ofs == ADDR_W'(`REG_SAVED) && sv != `SAVED_NONE) begin
         s_nxt.saved[sv] = wpsr;
         s_nxt.saved[sv].rsvd = 20'h00000;
      end
      // flags from the datapath
      if (flag_we_i) begin
         s_nxt.cur.nzcv = flags_i;
      end
      // core register port
      s_nxt.acc_err = !acc_ok(compact, rd_idx_i, hi_ok_i) ||
                      (wr_en_i && !acc_ok(compact, wr_idx_i, hi_ok_i));
      if (!acc_ok(compact, rd_idx_i, hi_ok_i)) begin
         s_nxt.rd_data = 32'h00000000;
      end else if (rd_idx_i == 4'hF) begin
         s_nxt.rd_data = pc_i;
      end else begin
         s_nxt.rd_data = s_r.gpr[phys(s_r.cur.mode, rd_idx_i)];
      end
      if (wr_en_i && wr_idx_i != 4'hF && acc_ok(compact, wr_idx_i, hi_ok_i)) begin
         s_nxt.gpr[phys(s_r.cur.mode, wr_idx_i)] = wr_data_i;
      end
      // only branches are conditional in compact state
      s_nxt.cond_pass = (compact && !branch_i) ? 1'b1 : cond_eval(cond_i, s_r.cur.nzcv);
      // return: pc from adjusted link, saved word back into current
      if (ret_i && !s_r.locked && sv != `SAVED_NONE) begin
         s_nxt.cur = s_r.saved[sv];
         s_nxt.pc = ret_pc_i;
         s_nxt.pc_load = 1'b1;
      end
      // entry overrides a return and any other update of the same fields in its cycle
      if (sel != status_word_pkg::EXC_NONE) begin
         s_nxt.rst_pend = 1'b0;
         s_nxt.last_exc = sel;
         if (sel != status_word_pkg::EXC_RESET) begin
            s_nxt.gpr[phys(nm, 4'hE)] = 32'(pc_i + lr_ofs(sel, compact));
            s_nxt.saved[nsv] = s_r.cur;
         end
         s_nxt.cur.mode = nm;
         s_nxt.cur.state = 1'b0;
         s_nxt.cur.imask = 1'b1;
         if (sel == status_word_pkg::EXC_FIQ || sel == status_word_pkg::EXC_RESET) begin
            s_nxt.cur.fmask = 1'b1;
         end
         s_nxt.pc = 32'(vbase + exc_vec(sel));
         s_nxt.pc_load = 1'b1;
      end
      // illegal mode freezes the core until reset
      if (!mode_legal(s_nxt.cur.mode)) begin
         s_nxt.locked = 1'b1;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
         s_r.cur <= status_word_pkg::psr_t'(`PSR_RESET);
         s_r.hivec <= 1'b0;
         s_r.rst_pend <= 1'b1;
         s_r.cond_pass <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata_o = s_r.prdata;
   assign pready_o = s_r.ready;
   assign pslverr_o = s_r.slverr;
   assign rd_data_o = s_r.rd_data;
   assign acc_err_o = s_r.acc_err;
   assign cond_pass_o = s_r.cond_pass;
   assign pc_load_o = s_r.pc_load;
   assign pc_o = s_r.pc;
   assign state_indicator_output_o = s_r.cur.state;
   assign mode_o = s_r.cur.mode;
   assign locked_o = s_r.locked;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   low_alias_a: assert property (
      wr_en_i && wr_idx_i < 4'h8 && sel == status_word_pkg::EXC_NONE
      |=> s_r.gpr[$past(wr_idx_i)] == $past(wr_data_i))
      else $error("low register write lost");

   hi_block_a: assert property (
      s_r.cur.state && !hi_ok_i && rd_idx_i inside {[4'h8:4'hC]}
      |=> acc_err_o && rd_data_o == 32'h00000000)
      else $error("high register reached in compact state");

   fiq_mask_a: assert property (
      s_r.cur.fmask |-> sel != status_word_pkg::EXC_FIQ)
      else $error("masked fast interrupt taken");

   prio_a: assert property (
      !s_r.rst_pend && !s_r.locked && boundary_i && dabt_i && fiq_i
      |-> sel == status_word_pkg::EXC_DABT)
      else $error("data abort lost priority");

   entry_fiq_a: assert property (
      sel == status_word_pkg::EXC_FIQ
      |=> pc_load_o && mode_o == `MODE_FIQ && !state_indicator_output_o &&
          pc_o == $past(vbase) + `VEC_FIQ && s_r.saved[0] == $past(s_r.cur))
      else $error("fast interrupt entry wrong");

   trap_lr_a: assert property (
      sel == status_word_pkg::EXC_SWT && s_r.cur.state
      |=> s_r.gpr[25] == $past(pc_i) + `LR_OFS_2)
      else $error("compact trap link value wrong");

   dabt_lr_a: assert property (
      sel == status_word_pkg::EXC_DABT
      |=> s_r.gpr[27] == $past(pc_i) + `LR_OFS_8 && mode_o == `MODE_ABT)
      else $error("data abort link value wrong");

   ret_copy_a: assert property (
      ret_i && !s_r.locked && sel == status_word_pkg::EXC_NONE &&
      s_r.cur.mode == `MODE_IRQ
      |=> pc_load_o && pc_o == $past(ret_pc_i) && s_r.cur == $past(s_r.saved[1]))
      else $error("return did not restore status word");

   user_ctrl_a: assert property (
      s_r.cur.mode == `MODE_USER && sel == status_word_pkg::EXC_NONE && !ret_i
      |=> s_r.cur.mode == `MODE_USER && $stable(s_r.cur.imask) && $stable(s_r.cur.fmask))
      else $error("control bits changed from user mode");

   cond_a: assert property (
      s_r.cur.state && !branch_i |=> cond_pass_o)
      else $error("compact non-branch was conditional");

endmodule

//--- status_word_and_exception_entry_test.sv
// testbench for the exception unit: apb registers, core port, entry and return
// assumes wait-free apb answers and exception entry one edge after a boundary
`timescale 1ns/1ns
`include "status_word_defs.svh"

module status_word_and_exception_entry_test;
   logic clk_sys_i, rstn_i, psel_i, penable_i, pwrite_i, boundary_i, dabt_i, fiq_i, irq_i;
   logic pabt_i, undef_i, swtrap_i, ret_i, flag_we_i, branch_i, hi_ok_i, wr_en_i;
   logic pready_o, pslverr_o, acc_err_o, cond_pass_o, pc_load_o, state_indicator_output_o;
   logic locked_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, pc_i, ret_pc_i, wr_data_i, rd_data_o, pc_o;
   logic [3:0] flags_i, cond_i, rd_idx_i, wr_idx_i;
   logic [4:0] mode_o;
   int n_mismatch, num_checks, cyc;
   localparam logic [31:0] hb = `VEC_HIGH_BASE;

   status_word_and_exception_entry #(.ADDR_W(12)) status_word_and_exception_entry_i (
      .clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .boundary_i, .pc_i, .dabt_i, .fiq_i, .irq_i, .pabt_i, .undef_i,
      .swtrap_i, .ret_i, .ret_pc_i, .flag_we_i, .flags_i, .cond_i, .branch_i, .rd_idx_i,
      .hi_ok_i, .wr_en_i, .wr_idx_i, .wr_data_i, .rd_data_o, .acc_err_o, .cond_pass_o,
      .pc_load_o, .pc_o, .state_indicator_output_o, .mode_o, .locked_o);

   // ----------------------------------------
   // clock, watchdog, verdict
   // ----------------------------------------
   always #5 clk_sys_i = ~clk_sys_i;

   // whole run is well under a thousand cycles
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic summarize();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %0t got %h want %h", $time, seen, exp);
      end
   endtask

   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] exp, input logic err);
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge clk_sys_i);
      end while (pready_o !== 1'b1);
      chk(32'(pready_o), 32'h1);
      chk(32'(pslverr_o), 32'(err));
      if (!wr && !err) chk(prdata_o, exp);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   // read port and condition test, answered one edge later
   task automatic rd(input logic [3:0] idx, input logic hi, input logic [3:0] c,
      input logic br, input logic [31:0] exp, input logic err, input logic cp);
      @(posedge clk_sys_i);
      rd_idx_i <= idx;
      hi_ok_i <= hi;
      cond_i <= c;
      branch_i <= br;
      @(posedge clk_sys_i);
      #1;
      chk(rd_data_o, exp);
      chk(32'(acc_err_o), 32'(err));
      chk(32'(cond_pass_o), 32'(cp));
   endtask

   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      @(posedge clk_sys_i);
      wr_en_i <= 1'b1;
      wr_idx_i <= idx;
      wr_data_i <= d;
      @(posedge clk_sys_i);
      wr_en_i <= 1'b0;
   endtask

   // md of zero means the request must be refused
   task automatic exc(input logic [5:0] rq, input logic [31:0] pc, input logic [31:0] vec,
      input logic [4:0] md);
      @(posedge clk_sys_i);
      {dabt_i, fiq_i, irq_i, pabt_i, undef_i, swtrap_i} <= rq;
      boundary_i <= 1'b1;
      pc_i <= pc;
      @(posedge clk_sys_i);
      {dabt_i, fiq_i, irq_i, pabt_i, undef_i, swtrap_i} <= 6'h00;
      boundary_i <= 1'b0;
      #1;
      chk(32'(pc_load_o), 32'(md != 5'h00));
      if (md != 5'h00) begin
         chk(pc_o, vec);
         chk(32'(mode_o), 32'(md));
         chk(32'(state_indicator_output_o), 32'h0);
      end
   endtask

   task automatic ret(input logic [31:0] pc, input logic [4:0] md, input logic st);
      @(posedge clk_sys_i);
      ret_i <= 1'b1;
      ret_pc_i <= pc;
      @(posedge clk_sys_i);
      ret_i <= 1'b0;
      #1;
      chk(32'(pc_load_o), 32'h1);
      chk(pc_o, pc);
      chk(32'(mode_o), 32'(md));
      chk(32'(state_indicator_output_o), 32'(st));
   endtask

   task automatic boot();
      @(posedge clk_sys_i);
      #1;
      chk(32'(pc_load_o), 32'h1);
      chk(pc_o, `VEC_LOW_BASE + `VEC_RESET);
      chk(32'(mode_o), 32'(`MODE_SVC));
      chk(32'(locked_o), 32'h0);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {clk_sys_i, rstn_i, psel_i, penable_i, pwrite_i, boundary_i, dabt_i, fiq_i} = '0;
      {irq_i, pabt_i, undef_i, swtrap_i, ret_i, flag_we_i, branch_i, hi_ok_i, wr_en_i} = '0;
      {paddr_i, pwdata_i, pc_i, ret_pc_i, wr_data_i} = '0;
      {flags_i, cond_i, rd_idx_i, wr_idx_i} = '0;
      {n_mismatch, num_checks, cyc} = '0;
      repeat (16) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      boot();
      apb(1'b0, `REG_CUR, 32'h0, `PSR_RESET, 1'b0);
      apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
      @(posedge clk_sys_i);
      flag_we_i <= 1'b1;
      flags_i <= 4'hA;
      @(posedge clk_sys_i);
      flag_we_i <= 1'b0;
      apb(1'b0, `REG_CUR, 32'h0, 32'hA00000D3, 1'b0);
      rd(4'h0, 1'b0, 4'h4, 1'b0, 32'h0, 1'b0, 1'b1);
      rd(4'h0, 1'b0, 4'h5, 1'b0, 32'h0, 1'b0, 1'b0);
      exc(6'h08, 32'h100, 32'h0, 5'h00);
      exc(6'h10, 32'h100, 32'h0, 5'h00);
      apb(1'b1, `REG_CTRL, 32'h1, 32'h0, 1'b0);
      apb(1'b1, `REG_CUR, 32'hA0000013, 32'h0, 1'b0);
      apb(1'b0, `REG_CUR, 32'h0, 32'hA0000013, 1'b0);
      wr(4'h8, 32'h88);
      wr(4'hD, 32'h5D);
      // every request at once: the abort on data wins
      exc(6'h3F, 32'h100, hb + `VEC_DABT, `MODE_ABT);
      rd(4'hE, 1'b0, 4'hE, 1'b0, 32'h108, 1'b0, 1'b1);
      apb(1'b0, `REG_SAVED, 32'h0, 32'hA0000013, 1'b0);
      exc(6'h18, 32'h200, hb + `VEC_FIQ, `MODE_FIQ);
      rd(4'hE, 1'b0, 4'hE, 1'b0, 32'h204, 1'b0, 1'b1);
      rd(4'h8, 1'b0, 4'hE, 1'b0, 32'h0, 1'b0, 1'b1);
      ret(32'h200, `MODE_ABT, 1'b0);
      rd(4'h8, 1'b0, 4'hE, 1'b0, 32'h88, 1'b0, 1'b1);
      rd(4'hD, 1'b0, 4'hE, 1'b0, 32'h0, 1'b0, 1'b1);
      ret(32'h104, `MODE_SVC, 1'b0);
      rd(4'hD, 1'b0, 4'hE, 1'b0, 32'h5D, 1'b0, 1'b1);
      exc(6'h08, 32'h600, hb + `VEC_IRQ, `MODE_IRQ);
      rd(4'hE, 1'b0, 4'hE, 1'b0, 32'h604, 1'b0, 1'b1);
      ret(32'h600, `MODE_SVC, 1'b0);
      exc(6'h04, 32'h700, hb + `VEC_PABT, `MODE_ABT);
      rd(4'hE, 1'b0, 4'hE, 1'b0, 32'h704, 1'b0, 1'b1);
      ret(32'h700, `MODE_SVC, 1'b0);
      // compact user state reached only through a return
      apb(1'b1, `REG_SAVED, 32'h30, 32'h0, 1'b0);
      ret(32'h300, `MODE_USER, 1'b1);
      apb(1'b1, `REG_CUR, 32'hD1, 32'h0, 1'b0);
      apb(1'b0, `REG_CUR, 32'h0, 32'h30, 1'b0);
      apb(1'b0, `REG_SAVED, 32'h0, 32'h0, 1'b0);
      rd(4'h8, 1'b0, 4'hE, 1'b0, 32'h0, 1'b1, 1'b1);
      rd(4'h8, 1'b1, 4'hE, 1'b0, 32'h88, 1'b0, 1'b1);
      rd(4'hF, 1'b0, 4'hE, 1'b0, 32'h700, 1'b0, 1'b1);
      wr(4'h3, 32'h33);
      rd(4'h0, 1'b0, 4'h0, 1'b0, 32'h0, 1'b0, 1'b1);
      rd(4'h0, 1'b0, 4'h0, 1'b1, 32'h0, 1'b0, 1'b0);
      exc(6'h02, 32'h400, hb + `VEC_UND, `MODE_UND);
      rd(4'hE, 1'b0, 4'hE, 1'b0, 32'h402, 1'b0, 1'b1);
      apb(1'b0, `REG_SAVED, 32'h0, 32'h30, 1'b0);
      ret(32'h402, `MODE_USER, 1'b1);
      exc(6'h01, 32'h500, hb + `VEC_SWT, `MODE_SVC);
      rd(4'hE, 1'b0, 4'hE, 1'b0, 32'h502, 1'b0, 1'b1);
      rd(4'h3, 1'b0, 4'hE, 1'b0, 32'h33, 1'b0, 1'b1);
      // illegal mode locks the core until a reset
      apb(1'b1, `REG_CUR, 32'h15, 32'h0, 1'b0);
      apb(1'b0, `REG_INFO, 32'h0, 32'hF, 1'b0);
      chk(32'(locked_o), 32'h1);
      exc(6'h20, 32'h800, 32'h0, 5'h00);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      boot();
      summarize();
   end
endmodule
